// >>> hw/cansid_regs.sv
/*
 * Identifier registers of one CAN message buffer in standard mapping,
 * reached over AHB-Lite, with capture from the receiver and an
 * arbitration-field serialiser toward the transmitter.
 * Assumes protocol-engine signals are on sys_clk; a single AHB-Lite slave.
 */
// The address map and the AHB-Lite interface to the registers were decided locally.
// Behaviour
// - a standard identifier is an 11-bit value, bits 10 down to 0, held in the identifier registers.
// - in arbitration identifier bit 10 is sent first, then lower bits in descending order.
// - a numerically smaller identifier has the higher priority.
// - the low identifier register holds identifier bits 2..0 in bits 7..5; the high register holds bits 10..3.
// - a transmit buffer sends the remote-request bit from bit 4 of the low register.
// - a receive buffer stores the received remote-request bit in that flag.
// - the remote-request flag is 0 for a data frame and 1 for a remote frame.
// - a receive buffer sets the format flag in bit 3 to the received frame's format.
// - a transmit buffer uses the format flag to choose standard or extended identifier.
// - the format flag is 0 for standard 11-bit and 1 for extended 29-bit identifiers.
`timescale 1ns/100ps
`include "cansid_consts.svh"

module cansid_regs
   import cansid_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int ID_W = 11
) (
   input wire logic sys_clk, // system clock, 25 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic hsel, // slave select
   input wire logic [ADDR_W-1:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // response, always okay

   input wire logic txStart, // begin sending the arbitration field
   input wire logic bitTick, // engine consumed one bit
   output logic txBit, // arbitration bit
   output logic txBitValid, // txBit meaningful
   output logic txExtended, // format flag toward the engine
   output logic txDone, // last arbitration bit consumed

   input wire logic rxValid, // received identifier is valid
   input wire logic [ID_W-1:0] rxIdentifier, // received identifier
   input wire logic rxRemote, // received remote-request bit
   input wire logic rxExtended, // received format bit

   input wire logic [ID_W-1:0] rivalIdentifier, // competing identifier
   output logic ownWins // own identifier has priority
);

   // shifter sized for the longest arbitration field
   localparam int FRAME_W = 32;
   localparam int LEN_W = 6;

   cansid_bus_t bus_q, bus_d;
   logic [2:0] idx_q, idx_d;
   logic mapped_q, mapped_d;
   logic [31:0] rdata_q, rdata_d;
   logic [7:0] idHigh_q, idHigh_d;
   logic [7:0] idLow_q, idLow_d;
   logic [7:0] unused2_q, unused2_d;
   logic [7:0] unused3_q, unused3_d;
   logic isRx_q, isRx_d;
   logic captured_q, captured_d;
   logic ownWins_q, ownWins_d;

   logic addrTake;
   logic addrMapped;
   logic [2:0] addrIdx;
   logic wrCommit;
   logic [7:0] wbyte;
   logic [ID_W-1:0] ownId;
   logic [FRAME_W-1:0] frameVec;
   logic [LEN_W-1:0] frameLen;
   logic shfBusy;
   logic rxTake;
   logic txGo;
   logic [ID_W+1:0] stdField;
   logic [31:0] rdSel;

   // per-register write strobes
   logic wrHigh;
   logic wrLow;
   logic wrUnused2;
   logic wrUnused3;
   logic wrCtrl;
   logic wrStat;

   // address phase sampling
   assign addrTake = hsel & hready & htrans[`CANSID_HTRANS_ACT_BIT];
   assign addrIdx = haddr[`CANSID_IDX_MSB:`CANSID_IDX_LSB];
   assign addrMapped = (haddr[ADDR_W-1:`CANSID_DEC_LSB] == '0) &&
                       (addrIdx <= `CANSID_IDX_STAT);
   assign wrCommit = (bus_q == BUS_WRITE) && mapped_q;
   assign wbyte = hwdata[7:0];

   // one strobe per register, in the data phase of a mapped write
   assign wrHigh = wrCommit && (idx_q == `CANSID_IDX_HIGH);
   assign wrLow = wrCommit && (idx_q == `CANSID_IDX_LOW);
   assign wrUnused2 = wrCommit && (idx_q == `CANSID_IDX_UNUSED2);
   assign wrUnused3 = wrCommit && (idx_q == `CANSID_IDX_UNUSED3);
   assign wrCtrl = wrCommit && (idx_q == `CANSID_IDX_CTRL);
   assign wrStat = wrCommit && (idx_q == `CANSID_IDX_STAT);

   // 11-bit identifier: high byte then the top three low bits
   assign ownId = {idHigh_q,
                   idLow_q[`CANSID_IDLO_MSB:`CANSID_IDLO_LSB]};

   assign rxTake = rxValid & isRx_q;
   assign txGo = txStart & ~isRx_q;

   // standard field: identifier, remote bit, format bit
   assign stdField = {ownId, idLow_q[`CANSID_RTR_BIT],
                      idLow_q[`CANSID_IDE_BIT]};

   // arbitration field; standard ignores the third and fourth registers
   always_comb begin
      if (idLow_q[`CANSID_IDE_BIT] == `CANSID_FMT_EXT) begin
         frameVec = {idHigh_q, idLow_q, unused2_q, unused3_q};
         frameLen = `CANSID_EXT_LEN;
      end else begin
         // third and fourth registers take no part
         frameVec = {stdField, `CANSID_STD_PAD};
         frameLen = `CANSID_STD_LEN;
      end
   end

   // value of the indexed register, zero outside its low byte
   always_comb begin
      rdSel = '0;
      if (mapped_q) begin
         unique case (idx_q)
            `CANSID_IDX_HIGH: rdSel[7:0] = idHigh_q;
            `CANSID_IDX_LOW: rdSel[7:0] = idLow_q;
            `CANSID_IDX_UNUSED2: rdSel[7:0] = unused2_q;
            `CANSID_IDX_UNUSED3: rdSel[7:0] = unused3_q;
            `CANSID_IDX_CTRL: begin
               rdSel[`CANSID_CTRL_RX_BIT] = isRx_q;
            end
            `CANSID_IDX_STAT: begin
               rdSel[`CANSID_STAT_CAP_BIT] = captured_q;
               rdSel[`CANSID_STAT_BUSY_BIT] = shfBusy;
            end
            default: begin
               rdSel = '0;
            end
         endcase
      end
   end

   // bus phase tracking; reads take one wait state for registered data
   always_comb begin
      bus_d = bus_q;
      idx_d = idx_q;
      mapped_d = mapped_q;
      rdata_d = rdata_q;
      unique case (bus_q)
         BUS_RDWAIT: begin
            rdata_d = rdSel;
            bus_d = BUS_RDOUT;
         end
         BUS_IDLE, BUS_WRITE, BUS_RDOUT: begin
            if (addrTake) begin
               idx_d = addrIdx;
               mapped_d = addrMapped;
               bus_d = hwrite ? BUS_WRITE : BUS_RDWAIT;
            end else begin
               bus_d = BUS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_q <= BUS_IDLE;
         idx_q <= '0;
         mapped_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         bus_q <= bus_d;
         idx_q <= idx_d;
         mapped_q <= mapped_d;
         rdata_q <= rdata_d;
      end
   end

   // low only in the read wait cycle, while the data register loads
   assign hreadyout = (bus_q != BUS_RDWAIT);
   assign hrdata = rdata_q;
   assign hresp = `CANSID_HRESP_OKAY;

   // identifier bytes; a capture from the receiver wins over a write
   always_comb begin
      idHigh_d = idHigh_q;
      idLow_d = idLow_q;
      unused2_d = unused2_q;
      unused3_d = unused3_q;
      if (wrHigh) begin
         idHigh_d = wbyte;
      end
      if (wrLow) begin
         idLow_d = wbyte;
      end
      if (wrUnused2) begin
         unused2_d = wbyte;
      end
      if (wrUnused3) begin
         unused3_d = wbyte;
      end
      if (rxTake) begin
         // identifier bits 10..3 and 2..0 as received
         idHigh_d = rxIdentifier[ID_W-1:ID_W-8];
         idLow_d[`CANSID_IDLO_MSB:`CANSID_IDLO_LSB] = rxIdentifier[2:0];
         // remote bit stored as received, 1 for a remote frame
         idLow_d[`CANSID_RTR_BIT] = rxRemote;
         // format bit as received, 1 for extended
         idLow_d[`CANSID_IDE_BIT] = rxExtended;
         // third and fourth registers left as they are
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         idHigh_q <= `CANSID_REG_RST;
         idLow_q <= `CANSID_REG_RST;
         unused2_q <= `CANSID_REG_RST;
         unused3_q <= `CANSID_REG_RST;
      end else begin
         idHigh_q <= idHigh_d;
         idLow_q <= idLow_d;
         unused2_q <= unused2_d;
         unused3_q <= unused3_d;
      end
   end

   // role and sticky capture flag; a capture wins over a clear
   always_comb begin
      isRx_d = isRx_q;
      captured_d = captured_q;
      if (wrCtrl) begin
         isRx_d = wbyte[`CANSID_CTRL_RX_BIT];
      end
      if (wrStat && wbyte[`CANSID_STAT_CAP_BIT]) begin
         captured_d = 1'b0;
      end
      if (rxTake) begin
         captured_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         isRx_q <= `CANSID_CTRL_RST;
         captured_q <= 1'b0;
      end else begin
         isRx_q <= isRx_d;
         captured_q <= captured_d;
      end
   end

   // priority: smaller identifier wins; ties do not win
   always_comb begin
      ownWins_d = 1'b0;
      if (ownId < rivalIdentifier) begin
         ownWins_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ownWins_q <= 1'b0;
      end else begin
         ownWins_q <= ownWins_d;
      end
   end

   assign ownWins = ownWins_q;
   assign txExtended = idLow_q[`CANSID_IDE_BIT];

   cansid_arb_shift #(
      .W(FRAME_W),
      .CW(LEN_W)
   ) u_shift (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(txGo),
      .bitTick(bitTick),
      .vec(frameVec),
      .len(frameLen),
      .serBit(txBit),
      .serValid(txBitValid),
      .busy(shfBusy),
      .done(txDone)
   );

endmodule

// >>> hw/cansid_consts.svh
/*
 * Constants of the standard-mapping identifier buffer: register indices,
 * field positions, reset values and shift lengths.
 * Assumes inclusion by bare name from every file that uses them.
 */
`ifndef CANSID_CONSTS_SVH
`define CANSID_CONSTS_SVH

// register indices; byte address is four times the index
`define CANSID_IDX_HIGH 3'h0
`define CANSID_IDX_LOW 3'h1
`define CANSID_IDX_UNUSED2 3'h2
`define CANSID_IDX_UNUSED3 3'h3
`define CANSID_IDX_CTRL 3'h4
`define CANSID_IDX_STAT 3'h5
`define CANSID_IDX_LSB 2
`define CANSID_IDX_MSB 4
`define CANSID_DEC_LSB 5

// fields of the low identifier register
`define CANSID_IDLO_MSB 7
`define CANSID_IDLO_LSB 5
`define CANSID_RTR_BIT 4
`define CANSID_IDE_BIT 3

// own control and status bits
`define CANSID_CTRL_RX_BIT 0
`define CANSID_STAT_CAP_BIT 0
`define CANSID_STAT_BUSY_BIT 1

`define CANSID_REG_RST 8'h00
`define CANSID_CTRL_RST 1'b0

// identifier flag encodings
`define CANSID_FMT_STD 1'b0
`define CANSID_FMT_EXT 1'b1
`define CANSID_FRAME_DATA 1'b0
`define CANSID_FRAME_REMOTE 1'b1

// arbitration field lengths in bits
`define CANSID_STD_LEN 6'h0D
`define CANSID_EXT_LEN 6'h20
`define CANSID_STD_PAD 19'h00000

`define CANSID_HTRANS_ACT_BIT 1
`define CANSID_HRESP_OKAY 1'b0

`endif

// >>> hw/cansid_pkg.sv
/*
 * Types of the standard-mapping identifier buffer.
 * Assumes cansid_consts.svh for the numeric constants.
 */
package cansid_pkg;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_RDWAIT = 2'b11,
      BUS_RDOUT = 2'b10
   } cansid_bus_t;

   typedef enum logic {
      SHF_IDLE = 1'b0,
      SHF_RUN = 1'b1
   } cansid_shf_t;

endpackage

// >>> hw/cansid_arb_shift.sv
/*
 * Serialiser for the arbitration field: loads a frame vector on start and
 * sends it most significant bit first, one bit per bit tick.
 * Assumes start and bitTick come from protocol logic on sys_clk.
 */
`timescale 1ns/100ps
`include "cansid_consts.svh"

module cansid_arb_shift
   import cansid_pkg::*;
#(
   parameter int W = 32,
   parameter int CW = 6
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic start, // load vector and begin
   input wire logic bitTick, // advance one bit
   input wire logic [W-1:0] vec, // field, first bit at top
   input wire logic [CW-1:0] len, // number of bits to send
   output logic serBit, // current bit
   output logic serValid, // serBit is meaningful
   output logic busy, // shift in progress
   output logic done // last bit consumed
);

   cansid_shf_t state_q, state_d;
   logic [W-1:0] shift_q, shift_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic done_q, done_d;

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      unique case (state_q)
         SHF_IDLE: begin
            if (start) begin
               shift_d = vec;
               cnt_d = len;
               state_d = SHF_RUN;
            end
         end
         SHF_RUN: begin
            if (bitTick) begin
               shift_d = {shift_q[W-2:0], 1'b0}; // next lower bit
               cnt_d = cnt_q - CW'(1);
               if (cnt_q == CW'(1)) begin
                  state_d = SHF_IDLE;
                  done_d = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= SHF_IDLE;
         shift_q <= '0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign serBit = shift_q[W-1]; // top bit goes first
   assign serValid = (state_q == SHF_RUN);
   assign busy = (state_q == SHF_RUN);
   assign done = done_q;

endmodule

// >>> dv/cansid_regs_sva.sv
/* checker of cansid_regs: bus answer, arbitration shifter timing.
   bound to every cansid_regs instance; sees its ports only. */
`timescale 1ns/100ps
module cansid_regs_sva (
   input wire logic sys_clk, // clock
   input wire logic rst, // reset
   input wire logic hreadyout, // slave ready
   input wire logic [31:0] hrdata, // read data
   input wire logic hresp, // response
   input wire logic txStart, // start request
   input wire logic bitTick, // bit consumed
   input wire logic txBit, // arbitration bit
   input wire logic txBitValid, // bit meaningful
   input wire logic txExtended, // format flag
   input wire logic txDone // field sent
);
   logic [5:0] cnt_q;
   // ticks consumed in the current field
   always_ff @(posedge sys_clk)
      cnt_q <= (rst || !txBitValid) ? 6'h00 : cnt_q + 6'(bitTick);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_okay; hresp == 1'b0; endproperty
   property p_wait; !hreadyout |=> hreadyout; endproperty
   property p_byte; hrdata[31:8] == 24'h000000; endproperty
   property p_hold; txBitValid && !bitTick |=> $stable(txBit) && txBitValid;
   endproperty
   property p_start; $rose(txBitValid) |-> $past(txStart); endproperty
   property p_len; txDone |-> cnt_q == (txExtended ? 6'h20 : 6'h0D);
   endproperty
   property p_fmt; txBitValid && !txExtended && cnt_q == 6'h0C |-> !txBit;
   endproperty
   property p_pulse; txDone |=> !txDone; endproperty
   property p_end; txDone |-> $past(txBitValid) && !txBitValid; endproperty
   a_okay: assert property (p_okay)
      else $error("response not okay");
   a_wait: assert property (p_wait)
      else $error("wait state too long");
   a_byte: assert property (p_byte)
      else $error("upper read bits set");
   a_hold: assert property (p_hold)
      else $error("bit changed without tick");
   a_start: assert property (p_start)
      else $error("shift began unrequested");
   a_len: assert property (p_len)
      else $error("wrong field length");
   a_fmt: assert property (p_fmt)
      else $error("standard format bit not zero");
   a_pulse: assert property (p_pulse)
      else $error("done longer than a cycle");
   a_end: assert property (p_end)
      else $error("done not at field end");
   c_std: cover property (txDone && !txExtended);
   c_ext: cover property (txDone && txExtended);
   c_wait: cover property (!hreadyout);
endmodule
bind cansid_regs cansid_regs_sva chk_u (.sys_clk, .rst, .hreadyout,
   .hrdata, .hresp, .txStart, .bitTick, .txBit, .txBitValid, .txExtended,
   .txDone);

// >>> dv/can_node_model.sv
/* far-side node: consumes arbitration bits, offers received frames.
   assumes sys_clk domain; the bench calls offer. */
`timescale 1ns/100ps
module can_node_model (
   input wire logic sys_clk, // clock
   input wire logic rst, // reset
   input wire logic txBit, // bit from buffer
   input wire logic txBitValid, // bit meaningful
   input wire logic [3:0] tickGap, // one less than the idle cycles before each tick
   output logic bitTick, // bit consumed
   output logic rxValid, // frame offered
   output logic [10:0] rxIdentifier, // offered identifier
   output logic rxRemote, // offered remote bit
   output logic rxExtended, // offered format
   output logic [31:0] seenVec, // consumed bits, last at bit 0
   output logic [5:0] seenCnt // consumed bit count
);
   logic [3:0] gap_q = 4'h0;
   logic valid_q = 1'b0;
   initial begin
      bitTick = 1'b0;
      rxValid = 1'b0;
      rxIdentifier = 11'h000;
      rxRemote = 1'b0;
      rxExtended = 1'b0;
   end
   always @(posedge sys_clk) begin
      valid_q <= txBitValid;
      bitTick <= 1'b0;
      if (rst || !txBitValid)
         gap_q <= 4'h0;
      else if (!bitTick) begin
         bitTick <= gap_q >= tickGap;
         gap_q <= (gap_q >= tickGap) ? 4'h0 : gap_q + 4'h1;
      end
      if (txBitValid && !valid_q) begin
         seenVec <= 32'h0;
         seenCnt <= 6'h00;
      end else if (bitTick && txBitValid) begin
         seenVec <= {seenVec[30:0], txBit};
         seenCnt <= seenCnt + 6'h01;
      end
   end
   task automatic offer(input logic [10:0] id, input logic rem, ext);
      @(posedge sys_clk);
      rxValid <= 1'b1;
      rxIdentifier <= id;
      rxRemote <= rem;
      rxExtended <= ext;
      @(posedge sys_clk);
      rxValid <= 1'b0;
      rxIdentifier <= ~id;
      rxRemote <= ~rem;
      rxExtended <= ~ext;
   endtask
endmodule

// >>> dv/cansid_regs_bench.sv
/* self-checking bench of cansid_regs with a far-side node model.
   assumes 25 MHz clock and a reset held for 10 cycles. */
`timescale 1ns/100ps
`include "cansid_consts.svh"
module cansid_regs_bench;
   logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, txStart = 0;
   logic [11:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [31:0] hwdata = 0, hrdata, rd, seenVec;
   logic hreadyout, hresp, bitTick, txBit, txBitValid, txExtended, txDone;
   logic rxValid, rxRemote, rxExtended, ownWins;
   logic [10:0] rxIdentifier, rivalIdentifier = 0;
   logic [5:0] seenCnt;
   logic [3:0] tickGap = 0;
   int errTotal = 0, numChecks = 0, cyc = 0;
   always #20 sys_clk = ~sys_clk;
   cansid_regs dut_u (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .txStart, .bitTick, .txBit, .txBitValid, .txExtended, .txDone,
      .rxValid, .rxIdentifier, .rxRemote, .rxExtended, .rivalIdentifier,
      .ownWins);
   can_node_model node_u (.sys_clk, .rst, .txBit, .txBitValid, .tickGap,
      .bitTick, .rxValid, .rxIdentifier, .rxRemote, .rxExtended, .seenVec,
      .seenCnt);
   task automatic check(input logic [31:0] got, exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic closeOut;
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errTotal++;
         closeOut;
      end
   end
   task automatic bus(input logic w, input logic [2:0] i, input int wd);
      @(posedge sys_clk);
      hsel <= 1;
      htrans <= 2'b10;
      haddr <= {7'h00, i, 2'b00};
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic launch;
      @(posedge sys_clk) txStart <= 1;
      @(posedge sys_clk) txStart <= 0;
      for (int n = 0; n < 400 && txDone !== 1'b1; n++)
         @(posedge sys_clk);
      check(txDone, 1);
   endtask
   task automatic t_regs;
      logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
      for (int i = 0; i < 6; i++) begin
         bus(0, 3'(i), 0);
         check(rd, 0);
      end
      for (int i = 0; i < 4; i++) begin
         bus(1, 3'(i), pat[i]);
         bus(0, 3'(i), 0);
         check(rd, pat[i]);
      end
      bus(1, 3'h6, 'hFF);
      bus(0, 3'h6, 0);
      check(rd, 0);
   endtask
   task automatic t_ext;
      bus(1, `CANSID_IDX_HIGH, 'h96);
      bus(1, `CANSID_IDX_LOW, 'h3D);
      launch;
      check(txExtended, 1);
      check(seenCnt, 32);
      check(seenVec, 32'h963D3CC3);
   endtask
   task automatic t_tx(input logic [10:0] id, input logic rem, gap);
      tickGap <= {2'b00, gap, 1'b1};
      bus(1, `CANSID_IDX_HIGH, id[10:3]);
      bus(1, `CANSID_IDX_LOW, {id[2:0], rem, 4'h0});
      launch;
      check(seenCnt, 13);
      check(seenVec, {id, rem, 1'b0});
   endtask
   task automatic t_rx;
      node_u.offer(11'h7FF, 1, 1);
      bus(0, `CANSID_IDX_HIGH, 0);
      check(rd, 'h1E);
      bus(0, `CANSID_IDX_STAT, 0);
      check(rd, 0);
      bus(1, `CANSID_IDX_CTRL, 1);
      @(posedge sys_clk) txStart <= 1;
      @(posedge sys_clk) txStart <= 0;
      @(posedge sys_clk);
      check(txBitValid, 0);
      for (int k = 0; k < 2; k++) begin
         node_u.offer(k ? 11'h2C1 : 11'h6AB, k[0], !k[0]);
         bus(0, `CANSID_IDX_HIGH, 0);
         check(rd, k ? 8'h58 : 8'hD5);
         bus(0, `CANSID_IDX_LOW, 0);
         check(rd[7:3], k ? 5'b00110 : 5'b01101);
      end
      bus(0, `CANSID_IDX_UNUSED2, 0);
      check(rd, 'h3C);
      bus(0, `CANSID_IDX_STAT, 0);
      check(rd, 1);
      bus(1, `CANSID_IDX_STAT, 1);
      bus(0, `CANSID_IDX_STAT, 0);
      check(rd, 0);
   endtask
   task automatic t_prio;
      bus(1, `CANSID_IDX_HIGH, 'h80);
      bus(1, `CANSID_IDX_LOW, 0);
      for (int k = -1; k < 2; k++) begin
         rivalIdentifier <= 11'(11'h400 + k);
         repeat (2) @(posedge sys_clk);
         check(ownWins, k > 0);
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      t_regs;
      t_ext;
      t_tx(11'h5A3, 1, 1);
      t_tx(11'h0F1, 0, 0);
      t_rx;
      t_prio;
      closeOut;
   end
endmodule
